// >>> hw/io_ports_consts.vh
// constants for the port b, c and e control block
`ifndef IO_PORTS_CONSTS_VH
`define IO_PORTS_CONSTS_VH

// register byte offsets
`define OFS_PORT_B_DATA     8'h00
`define OFS_PORT_B_MODE     8'h04
`define OFS_CONV_MODE       8'h08
`define OFS_PORT_C_LATCH    8'h0C
`define OFS_PORT_C_DIR      8'h10
`define OFS_PORT_E_LATCH    8'h14
`define OFS_PORT_E_DIR      8'h18
`define OFS_PORT_E_FSEL     8'h1C

// reset values
`define RST_BYTE            8'h00
`define RST_CHAN            4'h0
`define RST_FSEL            5'h00
`define PORT_WIDTH          8

// read-back fills
`define ALL_ONES            8'hFF
`define PORT_B_MODE_FIXED   8'hE8
`define PORT_E_FSEL_FIXED   8'hE0

// port b mode register fields
`define PBM_IRQ_LSB         0
`define PBM_IRQ_MSB         2
`define PBM_TEST_SW         4

// port e function-select fields
`define PEF_TIMER_CAP       4
`define PEF_FIRST_IRQ       3
`define PEF_COUNT_DIR       2
`define PEF_SECOND_IRQ      1
`define PEF_THIRD_IRQ       0
`define PEF_STORE_MSB       4

// port b pins that have interrupt selects
`define PB_IRQ_PIN_FIRST    0
`define PB_IRQ_PIN_SECOND   1
`define PB_IRQ_PIN_THIRD    2

// port e pins with alternate functions
`define PE_PIN_THIRD_IRQ    0
`define PE_PIN_SECOND_IRQ   3
`define PE_PIN_COUNT_DIR    6
`define PE_PIN_SHARED       7

// converter channel code of port b pin 0; pin n is this plus n
`define CHAN_BASE           4'h4
`define CHAN_MSB            3

// bus constants
`define HTRANS_NONSEQ_BIT   1
`define ADDR_MSB            7
`define ADDR_WORD_LSB       2
`define ZERO_WORD           32'h0000_0000
`define IRQ_IDLE            1'b1
`define INPUT_IDLE          1'b0

`endif

// >>> hw/io_ports_b_c_e_control.v
// port b, c and e pin-function logic with an ahb-lite register slave
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "io_ports_consts.vh"

module io_ports_b_c_e_control (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [7:0] port_b_pin,
  input wire [7:0] port_c_pin_in,
  output wire [7:0] port_c_pin_out,
  output wire [7:0] port_c_pin_oe,
  input wire [7:0] port_e_pin_in,
  output wire [7:0] port_e_pin_out,
  output wire [7:0] port_e_pin_oe,
  output wire [7:0] analog_channel_select,
  output wire first_external_interrupt,
  output wire second_external_interrupt,
  output wire third_external_interrupt,
  output wire timer_capture_input,
  output wire count_direction_input,
  output wire test_pin_switch
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // channel code that selects port b pin n as analog input
  function analog_hit;
    input [3:0] chan;
    input [3:0] pin;
    begin
      analog_hit = (chan == (`CHAN_BASE + pin));
    end
  endfunction

  // mixed read: latch where direction set, pin level elsewhere
  function [7:0] mix_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      mix_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  // port b pins taken as analog inputs by a channel code
  function [7:0] analog_mask;
    input [3:0] chan;
    input [7:0] mode;
    integer n;
    begin
      analog_mask = `RST_BYTE;
      for (n = 0; n < `PORT_WIDTH; n = n + 1) begin
        analog_mask[n] = analog_hit(chan, n[3:0]);
      end
      analog_mask[`PB_IRQ_PIN_THIRD] =
        analog_mask[`PB_IRQ_PIN_THIRD] & ~mode[`PB_IRQ_PIN_THIRD];
      analog_mask[`PB_IRQ_PIN_SECOND] =
        analog_mask[`PB_IRQ_PIN_SECOND] & ~mode[`PB_IRQ_PIN_SECOND];
      analog_mask[`PB_IRQ_PIN_FIRST] =
        analog_mask[`PB_IRQ_PIN_FIRST] & ~mode[`PB_IRQ_PIN_FIRST];
    end
  endfunction

  // port e pins handed to an alternate function
  function [7:0] alt_mask;
    input [4:0] fsel;
    input [7:0] mode;
    begin
      alt_mask = `RST_BYTE;
      // pin e7 capture or first interrupt
      alt_mask[`PE_PIN_SHARED] = fsel[`PEF_TIMER_CAP] |
        (fsel[`PEF_FIRST_IRQ] & ~mode[`PB_IRQ_PIN_FIRST]);
      alt_mask[`PE_PIN_COUNT_DIR] = fsel[`PEF_COUNT_DIR];
      alt_mask[`PE_PIN_SECOND_IRQ] =
        fsel[`PEF_SECOND_IRQ] & ~mode[`PB_IRQ_PIN_SECOND];
      alt_mask[`PE_PIN_THIRD_IRQ] =
        fsel[`PEF_THIRD_IRQ] & ~mode[`PB_IRQ_PIN_THIRD];
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  reg [7:0] pb_meta_q;
  reg [7:0] pb_sync_q;
  reg [7:0] pc_meta_q;
  reg [7:0] pc_sync_q;
  reg [7:0] pe_meta_q;
  reg [7:0] pe_sync_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_meta_q <= `RST_BYTE;
      pb_sync_q <= `RST_BYTE;
      pc_meta_q <= `RST_BYTE;
      pc_sync_q <= `RST_BYTE;
      pe_meta_q <= `RST_BYTE;
      pe_sync_q <= `RST_BYTE;
    end else begin
      pb_meta_q <= port_b_pin;
      pb_sync_q <= pb_meta_q;
      pc_meta_q <= port_c_pin_in;
      pc_sync_q <= pc_meta_q;
      pe_meta_q <= port_e_pin_in;
      pe_sync_q <= pe_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // bus address phase capture
  // ----------------------------------------------------------------

  reg wr_pend_q;
  reg [`ADDR_MSB:0] wr_addr_q;
  wire addr_take;
  wire wr_take;
  wire rd_take;

  assign addr_take = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  assign wr_take = addr_take & hwrite;
  assign rd_take = addr_take & ~hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= `RST_BYTE;
    end else begin
      wr_pend_q <= wr_take;
      wr_addr_q <= {haddr[`ADDR_MSB:`ADDR_WORD_LSB], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  reg [7:0] pb_mode_q;
  reg [7:0] pb_mode_d;
  reg [3:0] chan_q;
  reg [3:0] chan_d;
  reg [7:0] pc_latch_q;
  reg [7:0] pc_latch_d;
  reg [7:0] pc_dir_q;
  reg [7:0] pc_dir_d;
  reg [7:0] pe_latch_q;
  reg [7:0] pe_latch_d;
  reg [7:0] pe_dir_q;
  reg [7:0] pe_dir_d;
  reg [4:0] pe_fsel_q;
  reg [4:0] pe_fsel_d;

  always @* begin
    pb_mode_d = pb_mode_q;
    chan_d = chan_q;
    pc_latch_d = pc_latch_q;
    pc_dir_d = pc_dir_q;
    pe_latch_d = pe_latch_q;
    pe_dir_d = pe_dir_q;
    pe_fsel_d = pe_fsel_q;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `OFS_PORT_B_MODE: begin
          pb_mode_d = hwdata[7:0] & ~`PORT_B_MODE_FIXED;
        end
        `OFS_CONV_MODE: begin
          chan_d = hwdata[`CHAN_MSB:0];
        end
        `OFS_PORT_C_LATCH: begin
          pc_latch_d = hwdata[7:0];
        end
        `OFS_PORT_C_DIR: begin
          pc_dir_d = hwdata[7:0];
        end
        `OFS_PORT_E_LATCH: begin
          pe_latch_d = hwdata[7:0];
        end
        `OFS_PORT_E_DIR: begin
          pe_dir_d = hwdata[7:0];
        end
        `OFS_PORT_E_FSEL: begin
          pe_fsel_d = hwdata[`PEF_STORE_MSB:0];
        end
        default: begin
          pb_mode_d = pb_mode_q;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pb_mode_q <= `RST_BYTE;
      chan_q <= `RST_CHAN;
      pc_latch_q <= `RST_BYTE;
      pc_dir_q <= `RST_BYTE;
      pe_latch_q <= `RST_BYTE;
      pe_dir_q <= `RST_BYTE;
      pe_fsel_q <= `RST_FSEL;
    end else begin
      pb_mode_q <= pb_mode_d;
      chan_q <= chan_d;
      pc_latch_q <= pc_latch_d;
      pc_dir_q <= pc_dir_d;
      pe_latch_q <= pe_latch_d;
      pe_dir_q <= pe_dir_d;
      pe_fsel_q <= pe_fsel_d;
    end
  end

  // ----------------------------------------------------------------
  // port b pin functions
  // ----------------------------------------------------------------

  reg [7:0] analog_sel;
  reg [7:0] pb_read;

  always @* begin
    analog_sel = analog_mask(chan_q, pb_mode_q);
    pb_read = pb_sync_q & ~analog_mask(chan_d, pb_mode_d);
  end

  assign analog_channel_select = analog_sel;
  assign test_pin_switch = pb_mode_q[`PBM_TEST_SW];

  // ----------------------------------------------------------------
  // port e pin functions
  // ----------------------------------------------------------------

  wire pb_irq_first;
  wire pb_irq_second;
  wire pb_irq_third;
  wire pe_irq_first;
  wire pe_irq_second;
  wire pe_irq_third;
  wire pe_cap;
  wire pe_ud;
  wire [7:0] pe_alt;

  assign pb_irq_first = pb_mode_q[`PB_IRQ_PIN_FIRST];
  assign pb_irq_second = pb_mode_q[`PB_IRQ_PIN_SECOND];
  assign pb_irq_third = pb_mode_q[`PB_IRQ_PIN_THIRD];
  // first interrupt on e7 unless port b owns it
  assign pe_irq_first = pe_fsel_q[`PEF_FIRST_IRQ] & ~pb_irq_first;
  assign pe_irq_second = pe_fsel_q[`PEF_SECOND_IRQ] & ~pb_irq_second;
  assign pe_irq_third = pe_fsel_q[`PEF_THIRD_IRQ] & ~pb_irq_third;
  assign pe_cap = pe_fsel_q[`PEF_TIMER_CAP] & ~pe_irq_first;
  assign pe_ud = pe_fsel_q[`PEF_COUNT_DIR];

  assign pe_alt = alt_mask(pe_fsel_q, pb_mode_q);

  assign port_c_pin_out = pc_latch_q;
  assign port_c_pin_oe = pc_dir_q;
  // port e drive only on general pins
  assign port_e_pin_out = pe_latch_q;
  assign port_e_pin_oe = pe_dir_q & ~pe_alt;

  assign timer_capture_input =
    pe_cap ? pe_sync_q[`PE_PIN_SHARED] : `INPUT_IDLE;
  assign count_direction_input =
    pe_ud ? pe_sync_q[`PE_PIN_COUNT_DIR] : `INPUT_IDLE;
  assign first_external_interrupt =
    pb_irq_first ? pb_sync_q[`PB_IRQ_PIN_FIRST] :
    pe_irq_first ? pe_sync_q[`PE_PIN_SHARED] : `IRQ_IDLE;
  assign second_external_interrupt =
    pb_irq_second ? pb_sync_q[`PB_IRQ_PIN_SECOND] :
    pe_irq_second ? pe_sync_q[`PE_PIN_SECOND_IRQ] : `IRQ_IDLE;
  assign third_external_interrupt =
    pb_irq_third ? pb_sync_q[`PB_IRQ_PIN_THIRD] :
    pe_irq_third ? pe_sync_q[`PE_PIN_THIRD_IRQ] : `IRQ_IDLE;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------

  reg [7:0] rd_byte;

  always @* begin
    case ({haddr[`ADDR_MSB:`ADDR_WORD_LSB], 2'b00})
      `OFS_PORT_B_DATA: begin
        rd_byte = pb_read;
      end
      `OFS_PORT_B_MODE: begin
        rd_byte = pb_mode_d | `PORT_B_MODE_FIXED;
      end
      `OFS_CONV_MODE: begin
        rd_byte = {4'h0, chan_d};
      end
      `OFS_PORT_C_LATCH: begin
        rd_byte = mix_read(pc_dir_d, pc_latch_d, pc_sync_q);
      end
      `OFS_PORT_C_DIR: begin
        rd_byte = `ALL_ONES;
      end
      `OFS_PORT_E_LATCH: begin
        rd_byte = mix_read(pe_dir_d & ~alt_mask(pe_fsel_d, pb_mode_d),
          pe_latch_d, pe_sync_q);
      end
      `OFS_PORT_E_DIR: begin
        rd_byte = `ALL_ONES;
      end
      `OFS_PORT_E_FSEL: begin
        rd_byte = `PORT_E_FSEL_FIXED | {3'b000, pe_fsel_d};
      end
      default: begin
        rd_byte = `RST_BYTE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `ZERO_WORD;
    end else if (rd_take) begin
      hrdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule // io_ports_b_c_e_control

// >>> test/io_ports_props.sv
// concurrent checks on the port control block's ports
`timescale 1ns/1ps
module io_ports_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [7:0] port_c_pin_out,
  input wire [7:0] port_c_pin_oe,
  input wire [7:0] port_e_pin_in,
  input wire [7:0] port_e_pin_oe,
  input wire timer_capture_input,
  input wire count_direction_input
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire [7:0] a = haddr[7:0];
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved with no read");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_cdir_ones: assert property (
    rd && a == 8'h10 |=> hrdata[7:0] == 8'hff)
    else $error("port c direction read not ones");
  a_edir_ones: assert property (
    rd && a == 8'h18 |=> hrdata[7:0] == 8'hff)
    else $error("port e direction read not ones");
  a_fsel_top: assert property (
    rd && a == 8'h1c |=> hrdata[7:5] == 3'b111)
    else $error("function select top bits not ones");
  a_cread_latch: assert property (
    rd && a == 8'h0c |=>
    ((hrdata[7:0] ^ port_c_pin_out) & port_c_pin_oe) == 8'h00)
    else $error("port c output bits not read from latch");
  a_cdir_reset: assert property (
    $rose(hresetn) |-> port_c_pin_oe == 8'h00)
    else $error("port c drives after reset");
  a_edir_reset: assert property (
    $rose(hresetn) |-> port_e_pin_oe == 8'h00)
    else $error("port e drives after reset");
  a_cap_pin: assert property (
    timer_capture_input |-> !port_e_pin_oe[7] && $past(port_e_pin_in[7], 2))
    else $error("capture input not from idle pin e7");
  a_count_pin: assert property (
    count_direction_input |-> !port_e_pin_oe[6] && $past(port_e_pin_in[6], 2))
    else $error("count input not from idle pin e6");
endmodule // io_ports_props

bind io_ports_b_c_e_control io_ports_props io_ports_props_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .port_c_pin_out, .port_c_pin_oe, .port_e_pin_in,
  .port_e_pin_oe, .timer_capture_input, .count_direction_input
);

// >>> test/pin_board_model.sv
// board model that drives the port pins
`timescale 1ns/1ps
module pin_board_model (
  input wire [7:0] b_drive,
  input wire [7:0] c_drive,
  input wire [7:0] e_drive,
  input wire [7:0] port_c_pin_out,
  input wire [7:0] port_c_pin_oe,
  input wire [7:0] port_e_pin_out,
  input wire [7:0] port_e_pin_oe,
  output wire [7:0] port_b_pin,
  output wire [7:0] port_c_pin_in,
  output wire [7:0] port_e_pin_in
);
  // wire level: device wins where it drives
  assign port_b_pin = b_drive;
  assign port_c_pin_in = (port_c_pin_oe & port_c_pin_out) |
    (~port_c_pin_oe & c_drive);
  assign port_e_pin_in = (port_e_pin_oe & port_e_pin_out) |
    (~port_e_pin_oe & e_drive);
endmodule // pin_board_model

// >>> test/test_io_ports_b_c_e_control.sv
// self-checking bench for the port control block
`timescale 1ns/1ps
module test_io_ports_b_c_e_control;
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  logic [7:0] b_drive, c_drive, e_drive;
  wire hready, hreadyout, hresp;
  wire [31:0] hrdata;
  wire [7:0] port_b_pin, port_c_pin_in, port_c_pin_out, port_c_pin_oe;
  wire [7:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe;
  wire [7:0] analog_channel_select;
  wire first_external_interrupt, second_external_interrupt;
  wire third_external_interrupt, timer_capture_input, count_direction_input;
  wire test_pin_switch;
  wire [4:0] alt = {timer_capture_input, first_external_interrupt,
    count_direction_input, second_external_interrupt,
    third_external_interrupt};
  wire [2:0] irq = {third_external_interrupt, second_external_interrupt,
    first_external_interrupt};
  int num_errors, cmp_count;
  assign hready = hreadyout;
  io_ports_b_c_e_control io_ports_b_c_e_control_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .port_b_pin,
    .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe, .port_e_pin_in,
    .port_e_pin_out, .port_e_pin_oe, .analog_channel_select,
    .first_external_interrupt, .second_external_interrupt,
    .third_external_interrupt, .timer_capture_input,
    .count_direction_input, .test_pin_switch);
  pin_board_model pin_board_model_inst (
    .b_drive, .c_drive, .e_drive, .port_c_pin_out, .port_c_pin_oe,
    .port_e_pin_out, .port_e_pin_oe, .port_b_pin, .port_c_pin_in,
    .port_e_pin_in);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        num_errors++;
        report_and_stop;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy;
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(n, e, r[7:0]);
  endtask
  task drive(input logic [7:0] b, input logic [7:0] c, input logic [7:0] e);
    @(posedge hclk);
    b_drive <= b;
    c_drive <= c;
    e_drive <= e;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
  endtask
  task t_reset;
    @(negedge hclk);
    chk("c oe idle", 8'h00, port_c_pin_oe);
    chk("e oe idle", 8'h00, port_e_pin_oe);
    chk("analog idle", 8'h00, analog_channel_select);
    chk("irq idle", 8'h07, {5'h0, irq});
    chk("cap idle", 8'h00, {7'h0, timer_capture_input});
    chk("count idle", 8'h00, {7'h0, count_direction_input});
    rd("c dir", 8'h10, 8'hff);
    rd("e dir", 8'h18, 8'hff);
    rd("fsel", 8'h1c, 8'he0);
    rd("b mode", 8'h04, 8'he8);
    rd("unmapped", 8'h20, 8'h00);
  endtask
  task t_port_c;
    wr(8'h10, 8'h0f);
    wr(8'h0c, 8'h3c);
    drive(8'hff, 8'ha5, 8'hff);
    chk("c oe", 8'h0f, port_c_pin_oe);
    chk("c out", 8'h3c, port_c_pin_out);
    rd("c data", 8'h0c, 8'hac);
  endtask
  task t_port_e;
    logic [7:0] m [5];
    m = '{8'h01, 8'h08, 8'h40, 8'h80, 8'h80};
    wr(8'h18, 8'hff);
    wr(8'h14, 8'h5a);
    drive(8'hff, 8'hff, 8'h00);
    chk("e oe", 8'hff, port_e_pin_oe);
    chk("e out", 8'h5a, port_e_pin_out);
    rd("e data", 8'h14, 8'h5a);
    for (int i = 0; i < 5; i++) begin
      wr(8'h1c, 8'h01 << i);
      rd("fsel", 8'h1c, 8'he0 | (8'h01 << i));
      drive(8'hff, 8'hff, 8'h00);
      chk("e oe alt", ~m[i], port_e_pin_oe);
      chk("alt low", 8'h00, {7'h0, alt[i]});
      drive(8'hff, 8'hff, 8'hff);
      chk("alt high", 8'h01, {7'h0, alt[i]});
      rd("e data alt", 8'h14, (8'h5a & ~m[i]) | m[i]);
    end
    wr(8'h1c, 8'h00);
  endtask
  task t_port_b;
    for (int n = 0; n < 3; n++) begin
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h04 + n[7:0]);
      drive(8'hff, 8'hff, 8'hff);
      chk("analog", 8'h01 << n, analog_channel_select);
      rd("b data", 8'h00, ~(8'h01 << n));
      rd("chan", 8'h08, 8'h04 + n[7:0]);
      wr(8'h08, 8'h00);
      wr(8'h04, 8'h01 << n);
      rd("b mode", 8'h04, 8'he8 | (8'h01 << n));
      drive(~(8'h01 << n), 8'hff, 8'hff);
      chk("irq low", 8'h00, {7'h0, irq[n]});
      drive(8'hff, 8'hff, 8'hff);
      chk("irq high", 8'h01, {7'h0, irq[n]});
    end
    wr(8'h04, 8'h10);
    rd("b mode sw", 8'h04, 8'hf8);
    drive(8'hff, 8'hff, 8'hff);
    chk("test switch", 8'h01, {7'h0, test_pin_switch});
    wr(8'h04, 8'h00);
    drive(8'hff, 8'hff, 8'hff);
    chk("test switch off", 8'h00, {7'h0, test_pin_switch});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    b_drive = 8'hff;
    c_drive = 8'hff;
    e_drive = 8'hff;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_port_c;
    t_port_e;
    t_port_b;
    report_and_stop;
  end
endmodule // test_io_ports_b_c_e_control
